/* File: hw/phy_mgmt_pkg.sv */
// Constants for the interrupt enable and communication status registers.
// Assumes a 16-bit management register port with one-cycle read latency.
package phy_mgmt_pkg;
  localparam logic [4:0] OFF_IRQ_ENABLE = 5'h16;
  localparam logic [4:0] OFF_COMM_STATUS = 5'h17;
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h18;
  localparam logic [4:0] OFF_CONTROL = 5'h19;
  localparam logic [15:0] IRQ_ENABLE_RESET = 16'h8000;
  // Writable bits of the enable register; reserved 13:12 and 4 read zero
  localparam logic [15:0] IRQ_ENABLE_WMASK = 16'hcfef;
  localparam int BIT_LINK_UP = 15;
  localparam int BIT_TX_MODE_LO = 13;
  localparam int BIT_LOC_RCVR = 12;
  localparam int BIT_REM_RCVR = 11;
  localparam int BIT_SCR_LOCK = 10;
  localparam int BIT_SSD = 9;
  localparam int BIT_ESD = 8;
  localparam int BIT_SQI_LO = 5;
  localparam int BIT_RX_ERR = 4;
  localparam int BIT_TX_ERR = 3;
  // Interrupt flag positions (same layout as the enable register)
  localparam int FLG_POWER_ON = 15;
  localparam int FLG_WAKE = 14;
  localparam int FLG_INIT_FAIL = 11;
  localparam int FLG_LINK_FAIL = 10;
  localparam int FLG_LINK_UP = 9;
  localparam int FLG_SYMBOL = 8;
  localparam int FLG_TRAINING = 7;
  localparam int FLG_QUALITY = 6;
  localparam int FLG_CONTROL = 5;
  localparam int FLG_UV = 3;
  localparam int FLG_UV_REC = 2;
  localparam int FLG_TEMP = 1;
  localparam int FLG_SLEEP_ABORT = 0;
  localparam logic [15:0] FLAGS_LOWPOWER_CLR = 16'h0740;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam int BIT_LINK_CONTROL = 0;
  localparam logic [2:0] SQI_RESET = 3'h0;
  localparam logic [1:0] TX_MODE_RESET = 2'h0;
  localparam logic [2:0] OP_STATE_IDLE = 3'h0;
endpackage : phy_mgmt_pkg

/* File: hw/input_sync.sv */
// Three-stage synchroniser for a bus of asynchronous status inputs.
// Assumes inputs may change at any time relative to core_clk.
`timescale 1ns/100ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } sync_state_t;
  sync_state_t state;
  sync_state_t next_state;
  genvar i;
  // Accept a change only once stages two and three agree
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      next_state.s1[i] = async_in[i];
      next_state.s2[i] = state.s1[i];
      next_state.s3[i] = state.s2[i];
      next_state.held[i] = (state.s2[i] == state.s3[i]) ? state.s3[i]
                                                          : state.held[i];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign sync_out = state.held;
endmodule : input_sync
`default_nettype wire

/* File: hw/phy_irq_enable_comm_status.sv */
// Interrupt enable and communication status registers of a 100 Mbit/s
// single-pair PHY, with interrupt flags and one level interrupt output.
// Assumes status inputs come from other clock domains of the PHY core.
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module phy_irq_enable_comm_status
  import phy_mgmt_pkg::*;
#(
  parameter int SYNC_W = 13
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic irq,
  input wire logic link_up,
  input wire logic [1:0] tx_mode,
  input wire logic local_receiver_ok,
  input wire logic remote_receiver_ok,
  input wire logic descrambler_lock,
  input wire logic start_delimiter_fault,
  input wire logic end_delimiter_fault,
  input wire logic [2:0] signal_quality_class,
  input wire logic receive_fault,
  input wire logic transmit_fault,
  input wire logic [2:0] operating_state,
  input wire logic [15:0] irq_event,
  input wire logic enter_sleep_request,
  input wire logic enter_uv_standby,
  input wire logic uv_in_standby
);
  import phy_mgmt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised status inputs
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] syn;
  assign raw_in = {link_up, tx_mode, local_receiver_ok, remote_receiver_ok,
                   descrambler_lock, start_delimiter_fault,
                   end_delimiter_fault, signal_quality_class, receive_fault,
                   transmit_fault};
  input_sync #(.WIDTH(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(syn)
  );
  logic s_link, s_loc, s_rem, s_scr, s_ssd, s_esd, s_rx, s_tx;
  logic [1:0] s_txm;
  logic [2:0] s_sqi;
  assign {s_link, s_txm, s_loc, s_rem, s_scr, s_ssd, s_esd, s_sqi, s_rx,
          s_tx} = syn;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] enable;
    logic [15:0] flags;
    logic link_control;
    logic link_prev;
    logic loc_ok;
    logic rem_ok;
    logic ssd;
    logic esd;
    logic rx_err;
    logic tx_err;
    logic [15:0] rdata;
    logic irq;
  } regs_t;
  regs_t r;
  regs_t next_r;

  logic rd_comm, rd_flags, wr_en, wr_ctl, lc;
  logic [15:0] comm_word;
  assign rd_comm = reg_read && reg_addr == OFF_COMM_STATUS;
  assign rd_flags = reg_read && reg_addr == OFF_IRQ_STATUS;
  assign wr_en = reg_write && reg_addr == OFF_IRQ_ENABLE;
  assign wr_ctl = reg_write && reg_addr == OFF_CONTROL;
  assign lc = r.link_control;

  always_comb begin
    comm_word = '0;
    comm_word[BIT_LINK_UP] = lc & s_link;
    comm_word[BIT_TX_MODE_LO+:2] = lc ? s_txm : TX_MODE_RESET;
    comm_word[BIT_LOC_RCVR] = r.loc_ok;
    comm_word[BIT_REM_RCVR] = r.rem_ok;
    comm_word[BIT_SCR_LOCK] = lc & s_scr;
    comm_word[BIT_SSD] = r.ssd;
    comm_word[BIT_ESD] = r.esd;
    comm_word[BIT_SQI_LO+:3] = lc ? s_sqi : SQI_RESET;
    comm_word[BIT_RX_ERR] = r.rx_err;
    comm_word[BIT_TX_ERR] = r.tx_err;
    // Operating state is not cleared by link control
    comm_word[2:0] = operating_state;
  end

  logic [15:0] ev;
  always_comb begin
    next_r = r;
    ev = irq_event;
    ev[FLG_LINK_FAIL] = r.link_prev & ~comm_word[BIT_LINK_UP];
    ev[FLG_LINK_UP] = ~r.link_prev & comm_word[BIT_LINK_UP];
    ev[13:12] = 2'h0;
    ev[4] = 1'b0;
    next_r.link_prev = comm_word[BIT_LINK_UP];
    if (wr_en) begin
      // Reserved bits are dropped whatever software writes
      next_r.enable = reg_wdata & IRQ_ENABLE_WMASK;
    end
    if (wr_ctl) begin
      next_r.link_control = reg_wdata[BIT_LINK_CONTROL];
    end
    // Flags: read clears, a new event in the same cycle wins
    if (rd_flags) begin
      next_r.flags = '0;
    end
    if (enter_sleep_request || enter_uv_standby || uv_in_standby) begin
      next_r.flags = next_r.flags & ~FLAGS_LOWPOWER_CLR;
    end
    next_r.flags = next_r.flags | ev;
    // Latched status: read rearms, current condition applies after it
    if (rd_comm) begin
      next_r.loc_ok = 1'b1;
      next_r.rem_ok = 1'b1;
      next_r.ssd = 1'b0;
      next_r.esd = 1'b0;
      next_r.rx_err = 1'b0;
      next_r.tx_err = 1'b0;
    end
    next_r.loc_ok = next_r.loc_ok & s_loc;
    next_r.rem_ok = next_r.rem_ok & s_rem;
    next_r.ssd = next_r.ssd | s_ssd;
    next_r.esd = next_r.esd | s_esd;
    next_r.rx_err = next_r.rx_err | s_rx;
    next_r.tx_err = next_r.tx_err | s_tx;
    if (!lc) begin
      next_r.loc_ok = 1'b0;
      next_r.rem_ok = 1'b0;
      next_r.ssd = 1'b0;
      next_r.esd = 1'b0;
      next_r.rx_err = 1'b0;
      next_r.tx_err = 1'b0;
    end
    next_r.rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        OFF_IRQ_ENABLE: next_r.rdata = r.enable;
        OFF_COMM_STATUS: next_r.rdata = comm_word;
        OFF_IRQ_STATUS: next_r.rdata = r.flags;
        OFF_CONTROL: next_r.rdata = {15'h0000, r.link_control};
        default: next_r.rdata = '0;
      endcase
    end
    next_r.irq = |(next_r.flags & next_r.enable);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.enable <= IRQ_ENABLE_RESET;
      r.flags <= FLAGS_RESET;
      r.link_control <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign irq = r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_enable_reset;
    @(posedge core_clk) $rose(rst_n) |-> r.enable == IRQ_ENABLE_RESET;
  endproperty
  a_enable_reset: assert property (p_enable_reset)
    else $error("enable register reset value wrong");
  property p_reserved_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (r.enable & ~IRQ_ENABLE_WMASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved enable bits not zero");
  // Only an event in the same cycle may survive a low-power clear
  property p_lowpower_clear;
    @(posedge core_clk) disable iff (!rst_n)
      (enter_sleep_request || enter_uv_standby || uv_in_standby)
      |=> (r.flags & FLAGS_LOWPOWER_CLR) ==
          ($past(ev) & FLAGS_LOWPOWER_CLR);
  endproperty
  a_lowpower_clear: assert property (p_lowpower_clear)
    else $error("low-power entry did not clear flags");
  property p_link_fail_flag;
    @(posedge core_clk) disable iff (!rst_n)
      (r.link_prev && !comm_word[BIT_LINK_UP]) |=> r.flags[FLG_LINK_FAIL];
  endproperty
  a_link_fail_flag: assert property (p_link_fail_flag)
    else $error("link fail flag not raised");
  property p_ssd_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (r.ssd && !rd_comm && lc && !wr_ctl) |=> r.ssd;
  endproperty
  a_ssd_hold: assert property (p_ssd_hold)
    else $error("start delimiter fault lost before read");
  property p_loc_latch;
    @(posedge core_clk) disable iff (!rst_n)
      (!r.loc_ok && !rd_comm) |=> !r.loc_ok;
  endproperty
  a_loc_latch: assert property (p_loc_latch)
    else $error("local receiver status rose without read");
  property p_lc_default;
    @(posedge core_clk) disable iff (!rst_n)
      !lc |=> (r.rx_err == 1'b0 && r.tx_err == 1'b0 && r.esd == 1'b0);
  endproperty
  a_lc_default: assert property (p_lc_default)
    else $error("latched fields not defaulted without link control");
  property p_irq_level;
    @(posedge core_clk) disable iff (!rst_n)
      irq == |(r.flags & r.enable);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with flags and enables");
endmodule : phy_irq_enable_comm_status
`default_nettype wire

/* File: testbench/phy_irq_enable_comm_status_tb_top.sv */
// Self-checking bench for the interrupt enable and status register block.
// Assumes the design package is compiled first; one 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module phy_irq_enable_comm_status_tb_top;
  import phy_mgmt_pkg::*;
  logic core_clk, rst_n, reg_write, reg_read, irq, link_up, descrambler_lock;
  logic local_receiver_ok, remote_receiver_ok, start_delimiter_fault;
  logic end_delimiter_fault, receive_fault, transmit_fault;
  logic enter_sleep_request, enter_uv_standby, uv_in_standby, rd_d;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, irq_event;
  logic [1:0] tx_mode;
  logic [2:0] signal_quality_class, operating_state;
  logic [15:0] exp_q[$];
  logic [31:0] seed;
  int n_fail, n_checks;
  phy_irq_enable_comm_status u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .link_up(link_up),
    .tx_mode(tx_mode), .local_receiver_ok(local_receiver_ok),
    .remote_receiver_ok(remote_receiver_ok),
    .descrambler_lock(descrambler_lock),
    .start_delimiter_fault(start_delimiter_fault),
    .end_delimiter_fault(end_delimiter_fault),
    .signal_quality_class(signal_quality_class),
    .receive_fault(receive_fault), .transmit_fault(transmit_fault),
    .operating_state(operating_state), .irq_event(irq_event),
    .enter_sleep_request(enter_sleep_request),
    .enter_uv_standby(enter_uv_standby), .uv_in_standby(uv_in_standby));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Expected status word; ok and flt give the latched bit states
  function automatic logic [15:0] st(input logic ok, input logic flt);
    st = {link_up, tx_mode, ok, ok, descrambler_lock, flt, flt,
      signal_quality_class, flt, flt, operating_state};
  endfunction : st
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_read <= 1'b0;
  endtask : rd
  task automatic ev(input logic [15:0] v);
    @(posedge core_clk);
    irq_event <= v;
    @(posedge core_clk);
    irq_event <= 16'h0000;
  endtask : ev
  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_d) chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_read;
  end
  initial begin
    idle(5000);
    n_fail++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reg_write, reg_read, link_up, descrambler_lock} = '0;
    {local_receiver_ok, remote_receiver_ok, start_delimiter_fault} = '0;
    {end_delimiter_fault, receive_fault, transmit_fault} = '0;
    {enter_sleep_request, enter_uv_standby, uv_in_standby} = '0;
    {reg_addr, reg_wdata, irq_event, tx_mode} = '0;
    {signal_quality_class, operating_state} = '0;
    seed = 32'h03d8ebde;
    idle(10);
    rst_n <= 1'b1;
    rd(5'h16, 16'h8000);
    rd(5'h17, 16'h0000);
    rd(5'h18, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(5'h16, seed[15:0] & 16'hcfef);
      rd(5'h16, seed[15:0] & 16'hcfef);
    end
    wr(5'h1f, 16'hffff);
    rd(5'h1f, 16'h0000);
    $display("test enable register done");
    wr(5'h16, 16'h0600);
    link_up <= 1'b1;
    idle(8);
    chk({15'h0, irq}, 16'h0001);
    rd(5'h18, 16'h0200);
    idle(2);
    chk({15'h0, irq}, 16'h0000);
    link_up <= 1'b0;
    idle(8);
    rd(5'h18, 16'h0400);
    wr(5'h16, 16'h0000);
    ev(16'h4000);
    idle(3);
    chk({15'h0, irq}, 16'h0000);
    wr(5'h16, 16'h4000);
    idle(2);
    chk({15'h0, irq}, 16'h0001);
    rd(5'h18, 16'h4000);
    for (int k = 0; k < 3; k++) begin
      ev(16'h4140);
      link_up <= ~link_up;
      idle(8);
      enter_sleep_request <= (k == 0);
      enter_uv_standby <= (k == 1);
      uv_in_standby <= (k == 2);
      idle(1);
      {enter_sleep_request, enter_uv_standby, uv_in_standby} <= 3'h0;
      idle(2);
      rd(5'h18, 16'h4000);
    end
    $display("test interrupts done");
    local_receiver_ok <= 1'b1;
    remote_receiver_ok <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      link_up <= seed[4];
      descrambler_lock <= seed[3];
      operating_state <= seed[2:0];
      tx_mode <= i[1:0];
      signal_quality_class <= i[2:0];
      idle(8);
      rd(5'h17, st(i > 0, 1'b0));
    end
    $display("test live status done");
    {local_receiver_ok, remote_receiver_ok} <= 2'b00;
    {start_delimiter_fault, end_delimiter_fault} <= 2'b11;
    {receive_fault, transmit_fault} <= 2'b11;
    idle(4);
    {local_receiver_ok, remote_receiver_ok} <= 2'b11;
    {start_delimiter_fault, end_delimiter_fault} <= 2'b00;
    {receive_fault, transmit_fault} <= 2'b00;
    idle(8);
    rd(5'h17, st(1'b0, 1'b1));
    rd(5'h17, st(1'b1, 1'b0));
    $display("test latched status done");
    wr(5'h19, 16'h0000);
    idle(2);
    rd(5'h17, {13'h0, operating_state});
    wr(5'h19, 16'h0001);
    rd(5'h19, 16'h0001);
    $display("test link control done");
    // Second reset in mid-run: enables and link control go back to reset
    rst_n <= 1'b0;
    idle(3);
    rst_n <= 1'b1;
    rd(5'h16, 16'h8000);
    rd(5'h19, 16'h0001);
    idle(3);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : phy_irq_enable_comm_status_tb_top
`default_nettype wire
